/* hdl/legacy_pkg.sv */
// constants and types shared by the legacy mode entry/exit logic
package legacy_pkg;
  // status longword field positions
  localparam int SLW_C       = 0;
  localparam int SLW_V       = 1;
  localparam int SLW_Z       = 2;
  localparam int SLW_N       = 3;
  localparam int SLW_T       = 4;
  localparam int SLW_INT_OVF = 5;
  localparam int SLW_FLT_UNF = 6;
  localparam int SLW_DEC_OVF = 7;
  localparam int SLW_MBZ_LO  = 8;
  localparam int SLW_MBZ_HI  = 15;
  localparam int SLW_PRIO_LO = 16;
  localparam int SLW_PRIO_HI = 20;
  localparam int SLW_PREV_LO = 22;
  localparam int SLW_PREV_HI = 23;
  localparam int SLW_CURM_LO = 24;
  localparam int SLW_CURM_HI = 25;
  localparam int SLW_ISTK    = 26;
  localparam int SLW_FPART   = 27;
  localparam int SLW_TPEND   = 30;
  localparam int SLW_LEG     = 31;
  localparam logic [1:0] USER_MODE = 2'h3;
  localparam logic [4:0] PRIO_ZERO = 5'h00;
  localparam logic [7:0] MBZ_ZERO  = 8'h00;
  // legacy word, page and chunk geometry
  localparam int LEG_W       = 16;
  localparam int PAGE_LO     = 9;
  localparam int PAGE_W      = 7;
  localparam int CHUNK_W     = 3;
  localparam int CCW_W       = 5;
  localparam int NUM_GPR     = 16;
  localparam int LEG_LAST_R  = 6;
  localparam int SCRATCH_R   = 7;
  localparam int PC_R        = 15;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] POPPSL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] PUSHED_OFS = 8'h0C;
  localparam logic [7:0] LPSW_OFS   = 8'h10;
  localparam logic [7:0] XLATE_OFS  = 8'h14;
  localparam logic [1:0] GPR_WIN    = 2'h1;
  // control and status bits
  localparam int CTRL_RET    = 0;
  localparam int CTRL_EXC    = 1;
  localparam int CTRL_INT    = 2;
  localparam int ST_LEGACY   = 0;
  localparam int ST_FAULT    = 1;
  localparam int ST_TPEND    = 2;
  localparam int ST_FPACC    = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic {NATIVE, LEGACY} mode_e;
endpackage

/* hdl/xlate_if.sv */
// legacy address translation request and result
`timescale 1ns/1ps
`default_nettype none
interface xlate_if;
  import legacy_pkg::*;
  logic                 req;
  logic [LEG_W-1:0]     legacy_addr;
  logic [31:0]          native_va;
  logic [PAGE_W-1:0]    page;
  logic [CHUNK_W-1:0]   chunk;
  logic [PAGE_LO-1:0]   offset;
  logic                 valid;
  modport requester (output req, output legacy_addr, input native_va, input page,
                     input chunk, input offset, input valid);
  modport mapper    (input req, input legacy_addr, output native_va, output page,
                     output chunk, output offset, output valid);
endinterface
`default_nettype wire

/* hdl/legacy_addr_map.sv */
// maps a 16-bit legacy address onto the native virtual address space
`timescale 1ns/1ps
`default_nettype none
module legacy_addr_map
  import legacy_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  resetn,
  xlate_if.mapper    xl
);
  typedef struct packed {
    logic [31:0]        va;
    logic [PAGE_W-1:0]  page;
    logic [CHUNK_W-1:0] chunk;
    logic [PAGE_LO-1:0] offset;
    logic               valid;
  } map_s;

  map_s r;
  map_s next_r;

  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (xl.req) begin
      next_r.va = {{(32-LEG_W){1'b0}}, xl.legacy_addr};
      next_r.page = xl.legacy_addr[LEG_W-1:PAGE_LO];
      next_r.offset = xl.legacy_addr[PAGE_LO-1:0];
      next_r.chunk = xl.legacy_addr[LEG_W-1:LEG_W-CHUNK_W];
      next_r.valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign xl.native_va = r.va;
  assign xl.page = r.page;
  assign xl.chunk = r.chunk;
  assign xl.offset = r.offset;
  assign xl.valid = r.valid;
endmodule
`default_nettype wire

/* hdl/legacy_mode_entry_exit.sv */
// legacy mode entry/exit, status checks and register mapping, on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module legacy_mode_entry_exit
  import legacy_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                mmu_fault,
  output logic                     legacy_mode,
  output logic                     rsvd_operand_fault,
  output logic                     legacy_exit,
  output logic [31:0]              native_va,
  output logic [PAGE_W-1:0]        va_page,
  output logic [CHUNK_W-1:0]       va_chunk,
  output logic                     va_valid
);
  typedef struct packed {
    mode_e                       mode;
    logic [CCW_W-1:0]            cc_word;
    logic                        trace_pend;
    logic                        fault;
    logic                        fault_pulse;
    logic                        exit_pulse;
    logic [31:0]                 pop_img;
    logic [31:0]                 push_img;
    logic                        ph_wr;
    logic [5:0]                  ph_idx;
    logic [31:0]                 rdata;
    logic [1:0]                  mf_sync;
    logic                        mf_prev;
    logic                        xreq;
    logic [LEG_W-1:0]            xaddr;
    logic [NUM_GPR-1:0][31:0]    gpr;
  } state_s;

  state_s r;
  state_s next_r;
  xlate_if xl ();

  legacy_addr_map u_map (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .xl      (xl)
  );

  assign xl.req = r.xreq;
  assign xl.legacy_addr = r.xaddr;

  // popped image checks for a legacy entry
  function automatic logic image_faults(input logic [31:0] img);
    logic bad;
    bad = 1'b0;
    if (img[SLW_DEC_OVF]) begin
      bad = 1'b1;
    end
    if (img[SLW_FLT_UNF]) begin
      bad = 1'b1;
    end
    if (img[SLW_INT_OVF]) begin
      bad = 1'b1;
    end
    if (img[SLW_ISTK]) begin
      bad = 1'b1;
    end
    if (img[SLW_FPART]) begin
      bad = 1'b1;
    end
    if (img[SLW_PRIO_HI:SLW_PRIO_LO] != PRIO_ZERO) begin
      bad = 1'b1;
    end
    if (img[SLW_PREV_HI:SLW_PREV_LO] != USER_MODE) begin
      bad = 1'b1;
    end
    if (img[SLW_CURM_HI:SLW_CURM_LO] != USER_MODE) begin
      bad = 1'b1;
    end
    // legacy entry: status bits 15:8 must be zero
    if (img[SLW_MBZ_HI:SLW_MBZ_LO] != MBZ_ZERO) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // legacy view of a native register
  function automatic logic [31:0] legacy_view(input logic [31:0] v);
    return {{(32-LEG_W){1'b0}}, v[LEG_W-1:0]};
  endfunction

  function automatic logic [31:0] exit_image(input logic [CCW_W-1:0] cc, input logic pend);
    logic [31:0] img;
    img = '0;
    img[SLW_LEG] = 1'b1;
    img[SLW_TPEND] = pend;
    img[SLW_PREV_HI:SLW_PREV_LO] = USER_MODE;
    img[SLW_CURM_HI:SLW_CURM_LO] = USER_MODE;
    img[SLW_T] = cc[SLW_T];
    img[SLW_N:SLW_C] = cc[SLW_N:SLW_C];
    return img;
  endfunction

  // software view of a general register in the current mode
  function automatic logic [31:0] gpr_read(input mode_e m, input logic [3:0] n, input logic [31:0] v);
    logic [31:0] res;
    res = v;
    // legacy view ignores upper halves of registers 0-6 and 15, reads register 7 as zero, returns 8-14 whole
    if (m == LEGACY) begin
      if (n == 4'(SCRATCH_R)) begin
        res = '0;
      end else if (n <= 4'(LEG_LAST_R) || n == 4'(PC_R)) begin
        res = legacy_view(v);
      end
    end
    return res;
  endfunction

  logic        wr_now;
  logic [31:0] wd;
  logic        mf_edge;
  logic        exit_evt;
  logic [3:0]  gidx;

  always_comb begin
    next_r = r;
    next_r.fault_pulse = 1'b0;
    next_r.exit_pulse = 1'b0;
    next_r.xreq = 1'b0;
    wr_now = r.ph_wr;
    wd = hwdata;
    gidx = r.ph_idx[3:0];
    exit_evt = 1'b0;

    // pin is synchronised; first stage read only by the second
    next_r.mf_sync = {r.mf_sync[0], mmu_fault};
    next_r.mf_prev = r.mf_sync[1];
    // edge, not level: a fault held for many cycles exits once
    mf_edge = r.mf_sync[1] && !r.mf_prev;

    // data phase of a write
    if (wr_now) begin
      if (r.ph_idx[5:4] == GPR_WIN) begin
        if (r.mode == NATIVE) begin
          next_r.gpr[gidx] = wd;
        end else if (gidx <= 4'(LEG_LAST_R) || gidx == 4'(PC_R)) begin
          next_r.gpr[gidx][LEG_W-1:0] = wd[LEG_W-1:0];
        end
      end else begin
        case ({r.ph_idx, 2'b00})
          CTRL_OFS: begin
            // entry only through a legacy-flagged return
            // refused images leave mode and flags untouched
            if (wd[CTRL_RET] && r.mode == NATIVE && r.pop_img[SLW_LEG]) begin
              if (image_faults(r.pop_img)) begin
                next_r.fault_pulse = 1'b1;
              end else begin
                next_r.mode = LEGACY;
                next_r.cc_word[SLW_T] = r.pop_img[SLW_T];
                next_r.cc_word[SLW_N:SLW_C] = r.pop_img[SLW_N:SLW_C];
                next_r.trace_pend = r.pop_img[SLW_TPEND];
              end
            end
            // control register exits by exception or interrupt; translation faults exit below
            if (wd[CTRL_EXC] && r.mode == LEGACY) begin
              exit_evt = 1'b1;
            end
            if (wd[CTRL_INT] && r.mode == LEGACY) begin
              exit_evt = 1'b1;
            end
          end
          POPPSL_OFS: next_r.pop_img = wd;
          STATUS_OFS: begin
            if (wd[ST_FAULT]) begin
              next_r.fault = 1'b0;
            end
          end
          LPSW_OFS: begin
            // native code sets these flags only through the entry image
            // legacy return ignores upper 11 bits
            if (r.mode == LEGACY) begin
              next_r.cc_word = wd[CCW_W-1:0];
            end
          end
          XLATE_OFS: begin
            next_r.xaddr = wd[LEG_W-1:0];
            next_r.xreq = 1'b1;
          end
          default: ;
        endcase
      end
    end

    // a fault seen in native mode belongs to native code
    // translation faults end legacy execution
    if (mf_edge && r.mode == LEGACY) begin
      exit_evt = 1'b1;
    end

    if (exit_evt) begin
      next_r.mode = NATIVE;
      next_r.exit_pulse = 1'b1;
      // image pushed on the way out
      next_r.push_img = exit_image(next_r.cc_word, next_r.trace_pend);
      // cleared, not kept: every exit leaves one defined state
      // upper halves of registers 0-6 and 15 cleared on exit
      for (int i = 0; i <= LEG_LAST_R; i++) begin
        next_r.gpr[i] = legacy_view(next_r.gpr[i]);
      end
      next_r.gpr[PC_R] = legacy_view(next_r.gpr[PC_R]);
    end

    // set wins over a same-cycle clear
    if (next_r.fault_pulse) begin
      next_r.fault = 1'b1;
    end

    // address phase: capture and prepare read data
    // read data from the next state, so a read right after a write sees it
    next_r.ph_wr = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_r.ph_wr = hwrite;
      next_r.ph_idx = haddr[7:2];
      if (!hwrite) begin
        next_r.rdata = '0;
        if (haddr[7:6] == GPR_WIN) begin
          next_r.rdata = gpr_read(next_r.mode, haddr[5:2], next_r.gpr[haddr[5:2]]);
        end else begin
          case ({haddr[7:2], 2'b00})
            POPPSL_OFS: next_r.rdata = next_r.pop_img;
            STATUS_OFS: begin
              next_r.rdata[ST_LEGACY] = (next_r.mode == LEGACY);
              next_r.rdata[ST_FAULT] = next_r.fault;
              next_r.rdata[ST_TPEND] = next_r.trace_pend;
              next_r.rdata[ST_FPACC] = 1'b0;
            end
            PUSHED_OFS: next_r.rdata = next_r.push_img;
            LPSW_OFS: next_r.rdata = {{(32-CCW_W){1'b0}}, next_r.cc_word};
            // last result; a fresh one lands two cycles after the write
            XLATE_OFS: next_r.rdata = xl.native_va;
            default: next_r.rdata = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign legacy_mode = (r.mode == LEGACY);
  assign rsvd_operand_fault = r.fault_pulse;
  assign legacy_exit = r.exit_pulse;
  assign native_va = xl.native_va;
  assign va_page = xl.page;
  assign va_chunk = xl.chunk;
  assign va_valid = xl.valid;
endmodule
`default_nettype wire

/* test/legacy_properties.sv */
// port assertions for the legacy mode entry/exit block
`timescale 1ns/1ps
`default_nettype none
module legacy_properties
  import legacy_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               legacy_mode,
  input wire logic               rsvd_operand_fault,
  input wire logic               legacy_exit,
  input wire logic [31:0]        native_va,
  input wire logic [PAGE_W-1:0]  va_page,
  input wire logic [CHUNK_W-1:0] va_chunk,
  input wire logic               va_valid
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence left_s;
    legacy_exit && !legacy_mode && $past(legacy_mode);
  endsequence
  sequence fresh_s;
    va_valid ##1 !va_valid;
  endsequence
  bus_ready_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
  refuse_native_a: assert property (rsvd_operand_fault |-> !legacy_mode)
    else $error("refused image entered legacy");
  refuse_pulse_a: assert property (rsvd_operand_fault |=> !rsvd_operand_fault && !legacy_mode)
    else $error("fault not a single pulse");
  exit_native_a: assert property (legacy_exit |-> left_s ##1 !legacy_exit)
    else $error("exit pulse without leaving");
  only_exit_a: assert property ($fell(legacy_mode) |-> legacy_exit)
    else $error("left legacy without exit");
  entry_clean_a: assert property ($rose(legacy_mode) |-> !legacy_exit && !rsvd_operand_fault)
    else $error("entry with fault or exit");
  va_low_a: assert property (va_valid |-> native_va[31:LEG_W] == 16'h0000)
    else $error("address above 64k");
  va_page_a: assert property (va_valid |-> va_page == native_va[15:PAGE_LO] && va_chunk == native_va[15:13])
    else $error("page or chunk wrong");
  va_pulse_a: assert property (va_valid |-> fresh_s)
    else $error("translation pulse too long");
  va_stand_a: assert property (!va_valid |-> $stable(native_va) && $stable(va_page))
    else $error("translation result moved");
endmodule
bind legacy_mode_entry_exit legacy_properties u_legacy_properties (.ref_clk, .resetn, .hreadyout, .hresp,
  .legacy_mode, .rsvd_operand_fault, .legacy_exit, .native_va, .va_page, .va_chunk, .va_valid);
`default_nettype wire

/* test/mmu_model.sv */
// memory management stand-in: faults on no-access pages
`timescale 1ns/1ps
`default_nettype none
module mmu_model
  import legacy_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              armed,
  input  wire logic              va_valid,
  input  wire logic [PAGE_W-1:0] va_page,
  output logic                   mmu_fault
);
  logic [2:0] hold = 3'h0;
  always @(posedge ref_clk) begin
    if (!resetn)
      hold <= 3'h0;
    else if (armed && va_valid && va_page >= 7'h21 && va_page <= 7'h4D)
      hold <= 3'h6;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  // held several cycles so the synchroniser cannot miss it
  assign mmu_fault = (hold != 3'h0);
endmodule
`default_nettype wire

/* test/legacy_mode_entry_exit_tb.sv */
// self-checking bench for the legacy mode entry/exit block
`timescale 1ns/1ps
`default_nettype none
module legacy_mode_entry_exit_tb;
  import legacy_pkg::*;
  logic               ref_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0;
  logic               rd_dp = 1'b0;
  logic               armed = 1'b0;
  logic [31:0]        hrdata, native_va;
  logic               hreadyout, hresp, mmu_fault, legacy_mode, rsvd_operand_fault, legacy_exit, va_valid;
  logic [PAGE_W-1:0]  va_page;
  logic [CHUNK_W-1:0] va_chunk;
  logic [31:0]        rq[$], vq[$], gpr[16];
  logic [31:0]        bad[9] = '{32'h0000_0080, 32'h0000_0040, 32'h0000_0020, 32'h0001_0000, 32'h0400_0000,
                                 32'h0800_0000, 32'h0040_0000, 32'h0100_0000, 32'h0000_0100};
  int                 error_cnt = 0, checks = 0, seed = 32'h73A121F3;
  always #20 ref_clk = ~ref_clk;
  legacy_mode_entry_exit u_legacy_mode_entry_exit (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mmu_fault, .legacy_mode,
    .rsvd_operand_fault, .legacy_exit, .native_va, .va_page, .va_chunk, .va_valid);
  mmu_model u_mmu_model (.ref_clk, .resetn, .armed, .va_valid, .va_page, .mmu_fault);
  task automatic fail(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("read %h want %h", got, exp));
  endtask
  task automatic cmp_va(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("va %h want %h", got, exp));
  endtask
  always @(posedge ref_clk) begin
    if (rd_dp && hreadyout === 1'b1) cmp_rd(hrdata, rq.pop_front());
    if (va_valid === 1'b1) cmp_va(native_va, vq.pop_front());
  end
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel   <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus({24'h0, a}, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus({24'h0, a}, 1'b0, 32'h0);
  endtask
  task automatic xl(input logic [15:0] a);
    vq.push_back({16'h0000, a});
    wr(XLATE_OFS, {16'hFFFF, a});
  endtask
  task automatic enter(input logic [31:0] p);
    wr(POPPSL_OFS, p);
    wr(CTRL_OFS, 32'h1);
  endtask
  function automatic logic [7:0] ga(input int n);
    return {GPR_WIN, n[3:0], 2'h0};
  endfunction
  function automatic logic [31:0] exp_gpr(input int n);
    return (n > SCRATCH_R && n < PC_R) ? gpr[n] : {16'h0000, gpr[n][15:0]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    fail("watchdog expired");
    end_of_test();
  end
  initial begin
    logic [31:0] g;
    logic [4:0]  cc;
    logic        pend;
    g = 32'h83C0_0000;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(STATUS_OFS, 32'h0);
    rd(PUSHED_OFS, 32'h0);
    rd(8'h30, 32'h0);
    $display("test reset done");
    foreach (bad[i]) begin
      enter((g ^ bad[i]) | ($random(seed) & 32'h4000_001F));
      rd(STATUS_OFS, 32'h2);
      wr(STATUS_OFS, 32'h2);
    end
    enter(32'h03C0_0000);
    rd(STATUS_OFS, 32'h0);
    $display("test refusals done");
    for (int n = 0; n < NUM_GPR; n++) begin
      gpr[n] = $random(seed);
      wr(ga(n), gpr[n]);
    end
    // exit kinds: exception, interrupt, memory fault
    for (int k = 0; k < 3; k++) begin
      cc   = 5'($random(seed));
      pend = 1'($random(seed));
      enter(g | {1'b0, pend, 25'h0, cc});
      rd(STATUS_OFS, {29'h0, pend, 2'h1});
      rd(LPSW_OFS, {27'h0, cc});
      if (k == 0) begin
        for (int n = 0; n < NUM_GPR; n++)
          rd(ga(n), n == SCRATCH_R ? 32'h0 : exp_gpr(n));
        wr(ga(9), 32'h0);
        wr(ga(3), 32'hFFFF_A5C3);
        gpr[3][15:0] = 16'hA5C3;
        cc = 5'($random(seed));
        wr(LPSW_OFS, {16'h0, 11'h7FF, cc});
        rd(LPSW_OFS, {27'h0, cc});
        xl(16'h0000);
        xl(16'hFFFF);
        xl(16'($random(seed)));
      end
      if (k < 2)
        wr(CTRL_OFS, (k == 1) ? 32'h4 : 32'h2);
      else begin
        armed <= 1'b1;
        // page 40 has no access
        xl(16'h5000);
        for (int t = 0; t < 20 && legacy_mode === 1'b1; t++) @(posedge ref_clk);
        armed <= 1'b0;
      end
      // mode flop updates at the edge the write ends on; look one edge later
      @(posedge ref_clk);
      cmp_rd({31'h0, legacy_mode}, 32'h0);
      rd(PUSHED_OFS, {1'b1, pend, 8'h0F, 17'h0, cc});
      if (k == 0)
        for (int n = 0; n < NUM_GPR; n++)
          if (n != SCRATCH_R) rd(ga(n), exp_gpr(n));
      $display("test exit kind %0d done", k);
    end
    repeat (4) @(posedge ref_clk);
    if (vq.size() != 0) fail("translation missing");
    end_of_test();
  end
endmodule
`default_nettype wire
